//--- rtl/pmu_ctrl_pkg.sv
// package: register map, field positions, reset values and timing counts of the pmu control block
package pmu_ctrl_pkg;
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned WAKE_PULSE_MS   = 10;
  localparam int unsigned DEBOUNCE_MS     = 30;
  localparam int unsigned LONG_PRESS_MS   = 1000;
  localparam int unsigned WAKE_PULSE_CYC  = CLK_HZ / 1000 * WAKE_PULSE_MS;
  localparam int unsigned DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned LONG_PRESS_CYC  = CLK_HZ / 1000 * LONG_PRESS_MS;

  // byte addresses: printed register index times four
  localparam logic [7:0] IDX_SPARE_CFG    = 8'h0E;
  localparam logic [7:0] IDX_BATT_CTRL    = 8'h89;
  localparam logic [11:0] ADDR_SPARE_CFG  = {2'b00, IDX_SPARE_CFG, 2'b00};
  localparam logic [11:0] ADDR_BATT_CTRL  = {2'b00, IDX_BATT_CTRL, 2'b00};
  localparam logic [11:0] ADDR_ENSEL      = 12'h400;
  localparam logic [11:0] ADDR_WAKE       = 12'h404;
  localparam logic [11:0] ADDR_GPIO       = 12'h408;
  localparam logic [11:0] ADDR_STATUS     = 12'h40C;
  localparam logic [11:0] ADDR_THERM      = 12'h410;

  // spare config register
  localparam int unsigned SPARE_POL_BIT   = 4;
  localparam logic        SPARE_POL_RST   = 1'b1;
  // battery control register
  localparam int unsigned NO_BACKUP_BIT   = 7;
  localparam int unsigned ISOLATE_BIT     = 6;
  localparam int unsigned CHG_EN_N_BIT    = 5;
  localparam int unsigned CHG_SEL_BIT     = 4;
  localparam int unsigned FLT_LVL_LSB     = 2;
  localparam int unsigned CHG_CUR_LSB     = 0;
  localparam logic [7:0]  BATT_CTRL_RST   = 8'h20;
  // enable select register bits 0..2: ldo4, ldo5, buck2; 1 picks low-voltage enable
  localparam logic [2:0]  ENSEL_RST       = 3'b000;
  // wake reason bits
  localparam int unsigned WR_SPARE        = 0;
  localparam int unsigned WR_FIXTURE      = 1;
  localparam int unsigned WR_SHORT        = 2;
  localparam int unsigned WR_LONG         = 3;
  localparam int unsigned WR_THERMAL      = 4;
  // gpio control: bits [1:0] gpio one, [3:2] gpio two; level bits read at [5:4]
  localparam logic [3:0]  GPIO_CTRL_RST   = 4'h0;
  localparam int unsigned GPIO_IN_LSB     = 4;
  localparam int unsigned THERM_EN_BIT    = 3;
endpackage

//--- rtl/pmu_debounce.sv
// module: two-flop synchroniser and stable-level debounce filter
`timescale 1ns/100ps
module pmu_debounce
  import pmu_ctrl_pkg::*;
(
  input  wire logic i_clk,   // system clock
  input  wire logic i_rstn,  // sync reset, active low
  input  wire logic i_pin,   // raw pin level
  output logic      o_level  // debounced level
);
  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        lvl;
    logic [23:0] cnt;
  } deb_s;
  deb_s st_q;
  deb_s st_d;

  // accept a new level only after it held for the whole filter time
  always_comb begin
    st_d     = st_q;
    st_d.s1  = i_pin;
    st_d.s2  = st_q.s1;
    if (st_q.s2 == st_q.lvl) begin
      st_d.cnt = '0;
    end else if (st_q.cnt == 24'(DEBOUNCE_CYC - 1)) begin
      st_d.lvl = st_q.s2;
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + 24'h000001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_level = st_q.lvl;
endmodule

//--- rtl/pmu_ctrl.sv
// module: pmu control logic with wake-up, battery switch, charger, gpio and apb registers
`timescale 1ns/100ps
module pmu_ctrl
  import pmu_ctrl_pkg::*;
(
  input  wire logic        I_SYS_CLK,           // system clock, 125 MHz
  input  wire logic        I_RSTN,              // sync reset, active low
  // apb slave
  input  wire logic        PSEL,                // apb select
  input  wire logic        PENABLE,             // apb access phase
  input  wire logic        PWRITE,              // apb direction
  input  wire logic [11:0] PADDR,               // apb byte address
  input  wire logic [31:0] PWDATA,              // apb write data
  output logic             PREADY,              // apb ready
  output logic [31:0]      PRDATA,              // apb read data
  output logic             PSLVERR,             // apb error on unmapped
  // hardware enables and regulator requests
  input  wire logic        I_HIGH_VOLTAGE_POWER_ENABLE, // pin
  input  wire logic        I_LOW_VOLTAGE_POWER_ENABLE,  // pin
  output logic [2:0]       O_DOMAIN_HW_ENABLE,  // ldo4, ldo5, buck2 enables
  input  wire logic [8:0]  I_REG_IN_REGULATION, // analog ok per domain
  // wake-up
  input  wire logic        I_PUSH_BUTTON_WAKE_INPUT,  // push button, active high
  input  wire logic        I_TEST_FIXTURE_WAKE_INPUT_N, // fixture, active low
  input  wire logic        I_SPARE_WAKE_INPUT,  // spare, programmable polarity
  input  wire logic        I_THERMAL_WARNING,   // early warning comparator
  input  wire logic        I_THERMAL_SHUTDOWN,  // shutdown comparator
  output logic             O_WAKEUP,            // wake pulse to processor
  output logic             O_SYSTEM_RESET_N,    // system reset, active low
  // battery
  input  wire logic        I_MAIN_BELOW_LOW,    // main below 2.9 V comparator
  input  wire logic        I_MAIN_ABOVE_HIGH,   // main above 3.1 V comparator
  input  wire logic        I_MAIN_BELOW_FAULT,  // main below fault threshold
  input  wire logic        I_MAIN_PRESENT,      // main battery present
  output logic             O_RTC_FROM_BACKUP,   // rtc regulator on backup
  output logic             O_MAIN_BATTERY_FAULT_N, // battery fault, active low
  output logic [1:0]       O_FAULT_LEVEL,       // fault threshold code
  output logic [1:0]       O_CHARGER_CURRENT,   // charger current code
  output logic             O_CHARGER_ENABLE,    // backup charger on
  output logic             O_BACKUP_ISOLATE,    // backup draws no current
  // thermal flags
  output logic             O_THERM_FLAGS_ON,    // power the comparators
  input  wire logic [2:0]  I_THERM_FLAGS,       // comparator result code
  // gpio pins
  input  wire logic [1:0]  I_GPIO,              // pin levels
  output logic [1:0]       O_GPIO,              // pin drive value
  output logic [1:0]       O_GPIO_OE            // drive enable, high drives
);

  typedef struct packed {
    logic [1:0]  spare_s;
    logic [1:0]  warn_s;
    logic [1:0]  tsd_s;
    logic [1:0]  low_s;
    logic [1:0]  high_s;
    logic [1:0]  flt_s;
    logic [1:0]  pres_s;
    logic [8:0]  ok_s1;
    logic [8:0]  ok_s2;
    logic [2:0]  tf_s1;
    logic [2:0]  tf_s2;
    logic [1:0]  gi_s1;
    logic [1:0]  gi_s2;
    logic        spare_pol;
    logic [7:0]  batt;
    logic [2:0]  ensel;
    logic [3:0]  gctl;
    logic        therm_en;
    logic [4:0]  reason;
    logic [3:0]  prev;
    logic        btn_long;
    logic [27:0] btn_cnt;
    logic [20:0] wake_cnt;
    logic        backup;
    logic        rst_n;
    logic [31:0] rdata;
    logic        err;
  } ctrl_s;
  ctrl_s st_q;
  ctrl_s st_d;

  logic btn_lvl;
  logic fix_lvl;
  logic spr_lvl;
  logic shared_is_gpio;

  ////////////////////////////////////////////////////////////////////////
  // debounced wake inputs; spare polarity applied before the filter
  pmu_debounce u_deb_btn (
    .i_clk   (I_SYS_CLK),
    .i_rstn  (I_RSTN),
    .i_pin   (I_PUSH_BUTTON_WAKE_INPUT),
    .o_level (btn_lvl)
  );
  // fixture pin inverted ahead of the filter so the reset level matches idle
  pmu_debounce u_deb_fix (
    .i_clk   (I_SYS_CLK),
    .i_rstn  (I_RSTN),
    .i_pin   (!I_TEST_FIXTURE_WAKE_INPUT_N),
    .o_level (fix_lvl)
  );
  pmu_debounce u_deb_spr (
    .i_clk   (I_SYS_CLK),
    .i_rstn  (I_RSTN),
    .i_pin   (st_q.spare_s[1] ^ st_q.spare_pol),
    .o_level (spr_lvl)
  );

  assign shared_is_gpio = st_q.batt[CHG_SEL_BIT];

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic [4:0] ev;
    logic       acc;
    logic [11:0] a;
    ev    = '0;
    acc   = PSEL && PENABLE;
    a     = PADDR;
    st_d  = st_q;
    // synchronisers for pins and analog comparators
    st_d.spare_s = {st_q.spare_s[0], I_SPARE_WAKE_INPUT};
    st_d.warn_s  = {st_q.warn_s[0], I_THERMAL_WARNING};
    st_d.tsd_s   = {st_q.tsd_s[0], I_THERMAL_SHUTDOWN};
    st_d.low_s   = {st_q.low_s[0], I_MAIN_BELOW_LOW};
    st_d.high_s  = {st_q.high_s[0], I_MAIN_ABOVE_HIGH};
    st_d.flt_s   = {st_q.flt_s[0], I_MAIN_BELOW_FAULT};
    st_d.pres_s  = {st_q.pres_s[0], I_MAIN_PRESENT};
    st_d.ok_s1   = I_REG_IN_REGULATION;
    st_d.ok_s2   = st_q.ok_s1;
    st_d.tf_s1   = I_THERM_FLAGS;
    st_d.tf_s2   = st_q.tf_s1;
    st_d.gi_s1   = I_GPIO;
    st_d.gi_s2   = st_q.gi_s1;
    st_d.prev    = {st_q.warn_s[1], spr_lvl, fix_lvl, btn_lvl};

    // wake events on rising edge of the active level, debounced for spare and fixture, only synchronised for thermal warning
    ev[WR_SPARE]   = spr_lvl && !st_q.prev[2];
    ev[WR_FIXTURE] = fix_lvl && !st_q.prev[1];
    ev[WR_THERMAL] = st_q.warn_s[1] && !st_q.prev[3];
    // push button: count hold time, classify on release
    if (btn_lvl) begin
      if (st_q.btn_cnt == 28'(LONG_PRESS_CYC - 1)) begin
        st_d.btn_long = 1'b1;
      end else begin
        st_d.btn_cnt = st_q.btn_cnt + 28'h0000001;
      end
    end else begin
      st_d.btn_cnt  = '0;
      st_d.btn_long = 1'b0;
    end
    if (!btn_lvl && st_q.prev[0]) begin
      ev[WR_SHORT] = !st_q.btn_long;
      ev[WR_LONG]  = st_q.btn_long;
    end

    // wake pulse: any event (re)starts the 10 ms window
    if (|ev) begin
      st_d.wake_cnt = 21'(WAKE_PULSE_CYC);
    end else if (st_q.wake_cnt != '0) begin
      st_d.wake_cnt = st_q.wake_cnt - 21'h000001;
    end

    // battery switch with hysteresis and no-backup override
    if (st_q.batt[NO_BACKUP_BIT]) begin
      st_d.backup = 1'b0;
    end else if (!st_q.pres_s[1] || st_q.low_s[1]) begin
      st_d.backup = 1'b1;
    end else if (st_q.high_s[1]) begin
      st_d.backup = 1'b0;
    end

    // thermal shutdown holds reset while hot
    st_d.rst_n = !st_q.tsd_s[1];

    // apb access: write, read, reason clear-on-read
    st_d.rdata = '0;
    st_d.err   = 1'b0;
    if (acc && PWRITE) begin
      unique case (a)
        ADDR_SPARE_CFG: st_d.spare_pol = PWDATA[SPARE_POL_BIT];
        ADDR_BATT_CTRL: st_d.batt      = PWDATA[7:0];
        ADDR_ENSEL:     st_d.ensel     = PWDATA[2:0];
        ADDR_GPIO:      st_d.gctl      = PWDATA[3:0];
        ADDR_THERM:     st_d.therm_en  = PWDATA[THERM_EN_BIT];
        ADDR_WAKE, ADDR_STATUS: ;
        default:        st_d.err       = 1'b1;
      endcase
    end else if (acc) begin
      unique case (a)
        ADDR_SPARE_CFG: st_d.rdata[SPARE_POL_BIT] = st_q.spare_pol;
        ADDR_BATT_CTRL: st_d.rdata[7:0] = st_q.batt;
        ADDR_ENSEL:     st_d.rdata[2:0] = st_q.ensel;
        ADDR_WAKE: begin
          st_d.rdata[4:0] = st_q.reason;
          st_d.reason     = '0;
        end
        ADDR_GPIO: begin
          st_d.rdata[3:0] = st_q.gctl;
          st_d.rdata[GPIO_IN_LSB +: 2] = st_q.gi_s2 & gpio_in_mask();
        end
        ADDR_STATUS:    st_d.rdata[8:0] = st_q.ok_s2;
        ADDR_THERM: begin
          st_d.rdata[THERM_EN_BIT] = st_q.therm_en;
          st_d.rdata[2:0] = st_q.therm_en ? st_q.tf_s2 : 3'h0;
        end
        default:        st_d.err = 1'b1;
      endcase
    end
    // new events win over the read clear
    st_d.reason = st_d.reason | ev;
  end

  // a gpio reads its level only in input mode (01)
  function automatic logic [1:0] gpio_in_mask();
    logic [1:0] m;
    m = '0;
    for (int i = 0; i < 2; i++) begin
      m[i] = (st_q.gctl[2*i +: 2] == 2'b01);
    end
    m[0] = m[0] && shared_is_gpio;
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      st_q           <= '0;
      st_q.spare_pol <= SPARE_POL_RST;
      st_q.batt      <= BATT_CTRL_RST;
      st_q.ensel     <= ENSEL_RST;
      st_q.gctl      <= GPIO_CTRL_RST;
      st_q.rst_n     <= 1'b1;
      st_q.prev      <= 4'h0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign PREADY  = 1'b1;
  assign PRDATA  = st_q.rdata;
  assign PSLVERR = st_q.err;

  // hardware enable source per domain
  generate
    for (genvar g = 0; g < 3; g++) begin : g_ensel
      assign O_DOMAIN_HW_ENABLE[g] = st_q.ensel[g] ? I_LOW_VOLTAGE_POWER_ENABLE
                                                   : I_HIGH_VOLTAGE_POWER_ENABLE;
    end
  endgenerate

  assign O_WAKEUP               = (st_q.wake_cnt != '0);
  assign O_SYSTEM_RESET_N       = st_q.rst_n;
  assign O_RTC_FROM_BACKUP      = st_q.backup && !st_q.batt[ISOLATE_BIT];
  assign O_MAIN_BATTERY_FAULT_N = !(st_q.flt_s[1] || !st_q.pres_s[1]);
  assign O_FAULT_LEVEL          = st_q.batt[FLT_LVL_LSB +: 2];
  assign O_CHARGER_CURRENT      = st_q.batt[CHG_CUR_LSB +: 2];
  assign O_CHARGER_ENABLE       = !st_q.batt[ISOLATE_BIT] &&
                                  (!st_q.batt[CHG_EN_N_BIT] ||
                                   (!shared_is_gpio && !st_q.gi_s2[0]));
  assign O_BACKUP_ISOLATE       = st_q.batt[ISOLATE_BIT];
  assign O_THERM_FLAGS_ON       = st_q.therm_en;

  // gpio drive: 10 drive low, 11 drive high
  generate
    for (genvar p = 0; p < 2; p++) begin : g_gpio
      logic mode_ok;
      assign mode_ok      = (p != 0) || shared_is_gpio;
      assign O_GPIO[p]    = st_q.gctl[2*p];
      assign O_GPIO_OE[p] = mode_ok && st_q.gctl[2*p + 1];
    end
  endgenerate
endmodule

//--- testbench/pmu_ctrl_props.sv
// checker: port-level properties of the pmu control block
`timescale 1ns/100ps
module pmu_ctrl_checker
  import pmu_ctrl_pkg::*;
(
  input wire logic        I_SYS_CLK, I_RSTN, PSEL, PENABLE, PREADY, PSLVERR, // bus and clock
  input wire logic [11:0] PADDR,                                             // byte address
  input wire logic        I_HIGH_VOLTAGE_POWER_ENABLE, I_LOW_VOLTAGE_POWER_ENABLE, // enables
  input wire logic [2:0]  O_DOMAIN_HW_ENABLE,                                // domain enables
  input wire logic        I_THERMAL_WARNING, I_THERMAL_SHUTDOWN, O_WAKEUP, O_SYSTEM_RESET_N,
  input wire logic        I_MAIN_ABOVE_HIGH, I_MAIN_BELOW_FAULT, I_MAIN_PRESENT, // battery
  input wire logic        O_RTC_FROM_BACKUP, O_MAIN_BATTERY_FAULT_N, O_CHARGER_ENABLE,
  input wire logic        O_BACKUP_ISOLATE                                   // isolate
);
  ////////////////////////////////////////////////////////////
  // decoded access and address map
  wire logic acc    = PSEL && PENABLE;
  wire logic mapped = PADDR inside {ADDR_SPARE_CFG, ADDR_BATT_CTRL, ADDR_ENSEL, ADDR_WAKE,
                                    ADDR_GPIO, ADDR_STATUS, ADDR_THERM};
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);
  ////////////////////////////////////////////////////////////
  // bus answer
  apb_no_wait_a: assert property (acc |-> PREADY) else $error("access without ready");
  bad_addr_err_a: assert property (acc && !mapped |=> PSLVERR) else $error("no error on hole");
  good_addr_ok_a: assert property (acc && mapped |=> !PSLVERR) else $error("error on register");
  // enables, thermal and battery
  enable_select_a: assert property (I_HIGH_VOLTAGE_POWER_ENABLE == I_LOW_VOLTAGE_POWER_ENABLE
    |-> O_DOMAIN_HW_ENABLE == {3{I_HIGH_VOLTAGE_POWER_ENABLE}}) else $error("enable mux wrong");
  overheat_reset_a: assert property (I_THERMAL_SHUTDOWN [*5] |-> !O_SYSTEM_RESET_N)
    else $error("reset not held while hot");
  cool_release_a: assert property (!I_THERMAL_SHUTDOWN [*5] |-> O_SYSTEM_RESET_N)
    else $error("reset held while cool");
  warn_wake_a: assert property ($rose(I_THERMAL_WARNING) |-> ##[1:6] O_WAKEUP)
    else $error("no wake on warning");
  wake_pulse_a: assert property ($rose(O_WAKEUP) |=> O_WAKEUP [*8])
    else $error("wake pulse too short");
  fault_flag_a: assert property ((I_MAIN_BELOW_FAULT || !I_MAIN_PRESENT) [*5]
    |-> !O_MAIN_BATTERY_FAULT_N) else $error("fault flag not low");
  main_supply_a: assert property (I_MAIN_ABOVE_HIGH [*5] |-> !O_RTC_FROM_BACKUP)
    else $error("rtc on backup with good main");
  isolate_off_a: assert property (O_BACKUP_ISOLATE [*3]
    |-> !O_CHARGER_ENABLE && !O_RTC_FROM_BACKUP) else $error("isolated backup in use");
endmodule

bind pmu_ctrl pmu_ctrl_checker chk_u (.I_SYS_CLK, .I_RSTN, .PSEL, .PENABLE, .PREADY, .PSLVERR,
  .PADDR, .I_HIGH_VOLTAGE_POWER_ENABLE, .I_LOW_VOLTAGE_POWER_ENABLE, .O_DOMAIN_HW_ENABLE,
  .I_THERMAL_WARNING, .I_THERMAL_SHUTDOWN, .O_WAKEUP, .O_SYSTEM_RESET_N, .I_MAIN_ABOVE_HIGH,
  .I_MAIN_BELOW_FAULT, .I_MAIN_PRESENT, .O_RTC_FROM_BACKUP, .O_MAIN_BATTERY_FAULT_N,
  .O_CHARGER_ENABLE, .O_BACKUP_ISOLATE);

//--- testbench/pmu_host_model.sv
// host processor model: apb master for the pmu registers
`timescale 1ns/100ps
module pmu_host_model (
  input  wire logic  clk,                     // system clock
  input  wire logic  pready,                  // slave ready
  output logic       psel, penable, pwrite,   // bus controls
  output logic [11:0] paddr,                  // byte address
  output logic [31:0] pwdata                  // write data
);
  // idle bus at time zero
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // one transfer: setup, access until ready, then release with scrambled lines
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b0, 1'b0, ~w, ~a, ~d};
  endtask
endmodule

//--- testbench/pmu_wakeup_battery_gpio_control_bench.sv
// testbench: directed and random checks of the pmu control block
`timescale 1ns/100ps
module pmu_wakeup_battery_gpio_control_bench;
  import pmu_ctrl_pkg::*;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, rd_seen;
  logic        hv, lv, pb, fix_n, spare, twarn, tsd, blow, bhigh, bflt, bpres;
  logic        wake, rst_n, rtc_bk, flt_n, chg_en, iso, th_on;
  logic [1:0]  flvl, ccur, io_in, io_out, io_oe, ext_io;
  logic [2:0]  dom_en, tflags;
  logic [8:0]  reg_ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lfsr, r;
  logic [64:0] ent;
  logic [64:0] exp_q[$];
  int          n_errors, samples_checked, cycles;
  ////////////////////////////////////////////////////////////
  // clock and the shared gpio wire level
  always #4 clk = ~clk;
  assign io_in = (io_oe & io_out) | (~io_oe & ext_io);

  pmu_host_model host_u (.clk(clk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  pmu_ctrl dut_u (
    .I_SYS_CLK(clk), .I_RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .I_HIGH_VOLTAGE_POWER_ENABLE(hv), .I_LOW_VOLTAGE_POWER_ENABLE(lv), .O_DOMAIN_HW_ENABLE(dom_en),
    .I_REG_IN_REGULATION(reg_ok), .I_PUSH_BUTTON_WAKE_INPUT(pb), .I_TEST_FIXTURE_WAKE_INPUT_N(fix_n),
    .I_SPARE_WAKE_INPUT(spare), .I_THERMAL_WARNING(twarn), .I_THERMAL_SHUTDOWN(tsd),
    .O_WAKEUP(wake), .O_SYSTEM_RESET_N(rst_n), .I_MAIN_BELOW_LOW(blow), .I_MAIN_ABOVE_HIGH(bhigh),
    .I_MAIN_BELOW_FAULT(bflt), .I_MAIN_PRESENT(bpres), .O_RTC_FROM_BACKUP(rtc_bk),
    .O_MAIN_BATTERY_FAULT_N(flt_n), .O_FAULT_LEVEL(flvl), .O_CHARGER_CURRENT(ccur),
    .O_CHARGER_ENABLE(chg_en), .O_BACKUP_ISOLATE(iso), .O_THERM_FLAGS_ON(th_on),
    .I_THERM_FLAGS(tflags), .I_GPIO(io_in), .O_GPIO(io_out), .O_GPIO_OE(io_oe));
  ////////////////////////////////////////////////////////////
  // helpers: random source, compare, verdict, bus access, waits
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, m, input logic err);
    exp_q.push_back({err, m, e});
    host_u.xfer(1'b0, a, 32'h0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // read monitor: data and error land one cycle after the access edge
  always @(posedge clk) begin
    if (rd_seen) begin
      ent = exp_q.pop_front();
      check({pslverr, prdata & ent[63:32]}, {ent[64], ent[31:0] & ent[63:32]});
    end
    rd_seen <= psel & penable & pready & ~pwrite;
  end
  // cycle ceiling against hangs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {clk, rstn, rd_seen, hv, lv, pb, twarn, tsd, blow, bflt} = '0;
    {fix_n, spare, bhigh, bpres} = '1;
    {tflags, reg_ok, ext_io} = '0;
    lfsr = 32'hF930D7CB;
    tick(5);
    rstn <= 1'b1;
    rd(ADDR_SPARE_CFG, 32'h10, 32'h10, 1'b0);
    rd(ADDR_BATT_CTRL, {24'h0, BATT_CTRL_RST}, 32'hFF, 1'b0);
    rd(ADDR_ENSEL, 32'h0, 32'h7, 1'b0);
    rd(ADDR_GPIO, 32'h0, 32'h3F, 1'b0);
    rd(ADDR_THERM, 32'h0, 32'hF, 1'b0);
    rd(12'h7F0, 32'h0, 32'h0, 1'b1);
    wr(ADDR_SPARE_CFG, 32'h0);
    rd(ADDR_SPARE_CFG, 32'h0, 32'h10, 1'b0);
    wr(ADDR_SPARE_CFG, 32'h10);
    $display("test reset values done");
    // wake pins active for less than the filter window
    {fix_n, pb, spare} <= 3'b010;
    tick(40);
    {fix_n, pb, spare} <= 3'b101;
    tick(8);
    check(wake, 1'b0);
    rd(ADDR_WAKE, 32'h0, 32'h1F, 1'b0);
    // enable source select against random pin levels
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_ENSEL, 32'(i));
      r = rnd();
      {hv, lv} <= r[1:0];
      tick(2);
      check(dom_en, {i[2] ? lv : hv, i[1] ? lv : hv, i[0] ? lv : hv});
    end
    // fault level and charger current, then charger from pin, bit and gpio select
    r = rnd();
    wr(ADDR_BATT_CTRL, {24'h0, 4'h2, r[3:0]});
    tick(2);
    check({flvl, ccur}, r[3:0]);
    tick(6);
    check(chg_en, 1'b1);
    ext_io <= 2'b01;
    tick(6);
    check(chg_en, 1'b0);
    wr(ADDR_BATT_CTRL, 32'h0);
    tick(2);
    check(chg_en, 1'b1);
    wr(ADDR_BATT_CTRL, 32'h30);
    ext_io <= 2'b00;
    tick(6);
    check(chg_en, 1'b0);
    $display("test enables and charger done");
    // every gpio mode on both pins with random outside levels
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_GPIO, {28'h0, 2'(c), 2'(c)});
      r = rnd();
      ext_io <= r[1:0];
      tick(6);
      check({io_oe, io_out & io_oe}, {{2{c[1]}}, (c == 3) ? 2'b11 : 2'b00});
      rd(ADDR_GPIO, {26'h0, (c == 1) ? r[1:0] : 2'b00, 2'(c), 2'(c)}, 32'h3F, 1'b0);
    end
    $display("test gpio done");
    // early warning wake, read-to-clear reasons, shutdown reset
    twarn <= 1'b1;
    tick(8);
    check(wake, 1'b1);
    twarn <= 1'b0;
    rd(ADDR_WAKE, 32'h10, 32'h1F, 1'b0);
    rd(ADDR_WAKE, 32'h0, 32'h1F, 1'b0);
    tsd <= 1'b1;
    tick(20);
    check(rst_n, 1'b0);
    tsd <= 1'b0;
    tick(6);
    check(rst_n, 1'b1);
    $display("test thermal done");
    // comparator flags and regulation status
    r = rnd();
    {tflags, reg_ok} <= {r[2:0], r[12:4]};
    wr(ADDR_THERM, 32'h8);
    tick(4);
    check(th_on, 1'b1);
    rd(ADDR_THERM, {28'h0, 1'b1, r[2:0]}, 32'hF, 1'b0);
    rd(ADDR_STATUS, {23'h0, r[12:4]}, 32'h1FF, 1'b0);
    $display("test flags and status done");
    // battery switch hysteresis, fault flag, no-backup and isolate bits
    wr(ADDR_BATT_CTRL, 32'h20);
    {blow, bhigh} <= 2'b10;
    tick(6);
    check(rtc_bk, 1'b1);
    blow <= 1'b0;
    tick(6);
    check(rtc_bk, 1'b1);
    bhigh <= 1'b1;
    tick(6);
    check(rtc_bk, 1'b0);
    {bpres, bhigh, blow, bflt} <= 4'b0011;
    tick(6);
    check({flt_n, rtc_bk}, 2'b01);
    wr(ADDR_BATT_CTRL, 32'hA0);
    tick(2);
    check(rtc_bk, 1'b0);
    wr(ADDR_BATT_CTRL, 32'h60);
    tick(2);
    check({iso, chg_en, rtc_bk}, 3'b100);
    wr(ADDR_BATT_CTRL, 32'h20);
    tick(2);
    check(iso, 1'b0);
    $display("test battery done");
    tick(3);
    results();
  end
endmodule
